// File: common/sspf_pkg.sv
/*
 Package for the setpoint select and fault output block: register map,
 field codes, reset values and timing constants.
 Assumes a 40 MHz pclk and 32-bit APB data.
*/
package sspf_pkg;
   // Register byte offsets
   localparam logic [7:0] SSPF_CFG_OFS      = 8'h00;
   localparam logic [7:0] SSPF_SP_BASE_OFS  = 8'h04;
   localparam logic [7:0] SSPF_LIM_OFS      = 8'h14;
   localparam logic [7:0] SSPF_LEVEL_OFS    = 8'h18;
   localparam logic [7:0] SSPF_CMD_OFS      = 8'h1C;
   localparam logic [7:0] SSPF_INPUT_OFS    = 8'h20;
   localparam logic [7:0] SSPF_STATUS_OFS   = 8'h24;
   localparam logic [7:0] SSPF_OUT_OFS      = 8'h28;

   // Setpoint count codes
   typedef enum logic [1:0] {SSPF_CNT_ONE, SSPF_CNT_TWO, SSPF_CNT_FOUR} sspf_count_e;
   // Contact input function codes
   typedef enum logic [2:0] {SSPF_FN_NONE, SSPF_FN_HALT, SSPF_FN_ALCLR, SSPF_FN_MANUAL,
                             SSPF_FN_BANK} sspf_func_e;
   // Control direction
   typedef enum logic [1:0] {SSPF_DIR_HEAT, SSPF_DIR_COOL, SSPF_DIR_BOTH} sspf_dir_e;

   // Levels in tenths of a percent, signed
   localparam logic signed [11:0] SSPF_LVL_ZERO = 12'sh000;
   localparam logic signed [11:0] SSPF_LVL_FULL = 12'sh3E8;
   localparam logic signed [11:0] SSPF_LVL_NEG  = -12'sh3E8;

   // Blink half period
   localparam int unsigned SSPF_CLK_HZ       = 40000000;
   localparam int unsigned SSPF_BLINK_MS     = 500;
   localparam int unsigned SSPF_BLINK_CYC    = SSPF_CLK_HZ / 1000 * SSPF_BLINK_MS;

   // Reset values
   localparam logic [1:0] SSPF_CH_ONE = 2'h0;
   localparam logic [1:0] SSPF_CH_TWO = 2'h1;

   typedef struct packed {
      logic over;
      logic under;
      logic open;
   } sspf_fault_s;

   typedef struct packed {
      logic signed [11:0] heat;
      logic signed [11:0] cool;
   } sspf_level_s;
endpackage

// File: design/sspf_sync.sv
/*
 Two-stage synchroniser for a group of level inputs.
 Assumes inputs may change at any time relative to pclk.
*/
module sspf_sync
   import sspf_pkg::*;
#(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sspf_sync_s;

   sspf_sync_s state_reg;
   sspf_sync_s state_next;

   always_comb begin
      state_next.first  = async_in;
      state_next.second = state_reg.first;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.second;
endmodule

// File: design/sspf_top.sv
/*
 Setpoint select, contact input mapping and fault output arbitration,
 with an APB register slave.
 Assumes contact inputs and fault flags arrive from outside; fault flags
 and computed levels are synchronous to pclk.
*/
// The placing of the registers and register access over APB are this design's own decisions.
// What this block does
// - Setpoint count one, two or four
// - Four setpoints clamped to limits, default zero
// - Per-input function selector, default none
// - Sample contacts at power-up before acting
// - Halt input on channel one stops output, blocks bus run
// - Alarm clear input forces alarm off
// - Manual input forces manual, blocks bus mode
// - One bank input picks setpoint zero/one
// - Two bank inputs form index bits
// - Count drop from four turns input two off, or both if to one
// - Bank select only with count two+
// - Per-input target channel, defaults one/two
// - Fault flag follows range and open faults
// - Indicator blinks half second on fault
// - Heating only: over 0%, under 100%
// - Cooling only: over 100%, under 0%
// - Combined: over heat 0 cool 100
// - Manual priority: manual, halt, fault
// - Auto priority: halt, fault, computed
// - Open fault level, clamped per mode
// - Factory restore keeps communication parameters
// - Halt level overrides control levels
module sspf_top
   import sspf_pkg::*;
#(
   parameter int unsigned BLINK_CYC = SSPF_BLINK_CYC
) (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Contacts, closed is high
   input  wire logic        contact_input_one,
   input  wire logic        contact_input_two,
   // Sensor state per channel and computed levels
   input  wire sspf_fault_s fault_ch1,
   input  wire sspf_fault_s fault_ch2,
   input  wire sspf_level_s control_output_level,
   // Outputs
   output sspf_level_s      manipulated_value,
   output logic [1:0]       setpoint_index,
   output logic [15:0]      setpoint,
   output logic [1:0]       halt_ch,
   output logic [1:0]       alarm_force_off_ch,
   output logic [1:0]       manual_ch,
   output logic             fault_flag,
   output logic             indicator
);
   typedef struct packed {
      logic              started;
      sspf_count_e       count;
      sspf_func_e        func_one;
      sspf_func_e        func_two;
      logic [1:0]        ch_one;
      logic [1:0]        ch_two;
      sspf_dir_e         dir;
      logic              onoff;
      logic [1:0]        bus_index;
      logic [1:0]        bus_halt;
      logic [1:0]        bus_alclr;
      logic [1:0]        bus_manual;
      logic [63:0]       sp;
      logic [15:0]       sp_lo;
      logic [15:0]       sp_hi;
      logic signed [11:0] halt_lvl;
      logic signed [11:0] fault_lvl;
      logic signed [11:0] manual_lvl;
      logic [31:0]       blink_cnt;
      logic              blink;
      logic [31:0]       rdata;
      sspf_level_s       mv;
   } sspf_state_s;

   sspf_state_s state_reg;
   sspf_state_s state_next;
   logic [1:0]  contacts;
   logic [1:0]  act;
   logic        bank_one;
   logic        bank_two;
   logic        fault_any;
   logic        open_any;
   logic        over_any;
   logic        under_any;
   logic        wr;
   logic        rd;
   logic [7:0]  sp_ofs;
   logic [1:0]  halt_v;
   logic [1:0]  alclr_v;
   logic [1:0]  man_v;
   sspf_level_s fault_out;
   sspf_level_s halt_out;
   sspf_level_s manual_out;

   sspf_sync #(.WIDTH(2)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({contact_input_two, contact_input_one}),
      .sync_out (contacts)
   );

   function automatic logic signed [11:0] clamp_lvl(input logic signed [11:0] v,
                                                    input sspf_dir_e d, input logic oo);
      logic signed [11:0] r;
      r = v;
      if (oo) begin
         if (d == SSPF_DIR_BOTH) begin
            r = (v > SSPF_LVL_ZERO) ? SSPF_LVL_FULL :
                (v < SSPF_LVL_ZERO) ? SSPF_LVL_NEG : SSPF_LVL_ZERO;
         end else begin
            r = (v > SSPF_LVL_ZERO) ? SSPF_LVL_FULL : SSPF_LVL_ZERO;
         end
      end else if (v > SSPF_LVL_FULL) begin
         r = SSPF_LVL_FULL;
      end else if (d == SSPF_DIR_BOTH && v < SSPF_LVL_NEG) begin
         r = SSPF_LVL_NEG;
      end else if (d != SSPF_DIR_BOTH && v < SSPF_LVL_ZERO) begin
         r = SSPF_LVL_ZERO;
      end
      return r;
   endfunction

   function automatic sspf_level_s split_lvl(input logic signed [11:0] v, input sspf_dir_e d);
      sspf_level_s r;
      r = '0;
      unique case (d)
         SSPF_DIR_HEAT: r.heat = v;
         SSPF_DIR_COOL: r.cool = v;
         default: begin
            if (v < SSPF_LVL_ZERO) begin
               r.cool = -v;
            end else begin
               r.heat = v;
            end
         end
      endcase
      return r;
   endfunction

   // Functions act only after the synchroniser is primed
   assign act       = state_reg.started ? contacts : 2'h0;
   assign bank_one  = state_reg.func_one == SSPF_FN_BANK;
   assign bank_two  = state_reg.func_two == SSPF_FN_BANK;
   assign over_any  = fault_ch1.over | fault_ch2.over;
   assign under_any = fault_ch1.under | fault_ch2.under;
   assign open_any  = fault_ch1.open | fault_ch2.open;
   assign fault_any = over_any | under_any | open_any;
   assign wr        = psel & penable & pwrite;
   assign rd        = psel & ~penable & ~pwrite;
   assign sp_ofs    = paddr - SSPF_SP_BASE_OFS;

   // Per-channel contact functions
   always_comb begin
      halt_v  = state_reg.bus_halt;
      alclr_v = state_reg.bus_alclr;
      man_v   = state_reg.bus_manual;
      if (state_reg.func_one == SSPF_FN_HALT) begin
         halt_v[state_reg.ch_one[0]] = act[0];
      end
      if (state_reg.func_two == SSPF_FN_HALT) begin
         halt_v[state_reg.ch_two[0]] = act[1];
      end
      if (state_reg.func_one == SSPF_FN_ALCLR) begin
         alclr_v[state_reg.ch_one[0]] = act[0];
      end
      if (state_reg.func_two == SSPF_FN_ALCLR) begin
         alclr_v[state_reg.ch_two[0]] = act[1];
      end
      if (state_reg.func_one == SSPF_FN_MANUAL) begin
         man_v[state_reg.ch_one[0]] = act[0];
      end
      if (state_reg.func_two == SSPF_FN_MANUAL) begin
         man_v[state_reg.ch_two[0]] = act[1];
      end
   end

   // Output levels; channel one's halt and manual, and faults on either channel, drive the shared level output
   always_comb begin
      fault_out = '0;
      if (over_any) begin
         fault_out.heat = (state_reg.dir == SSPF_DIR_COOL) ? SSPF_LVL_ZERO : SSPF_LVL_ZERO;
         fault_out.cool = (state_reg.dir == SSPF_DIR_HEAT) ? SSPF_LVL_ZERO : SSPF_LVL_FULL;
      end else if (under_any) begin
         fault_out.heat = (state_reg.dir == SSPF_DIR_COOL) ? SSPF_LVL_ZERO : SSPF_LVL_FULL;
         fault_out.cool = SSPF_LVL_ZERO;
      end else if (open_any) begin
         fault_out = split_lvl(state_reg.fault_lvl, state_reg.dir);
      end
      halt_out   = split_lvl(state_reg.halt_lvl, state_reg.dir);
      manual_out = split_lvl(state_reg.manual_lvl, state_reg.dir);
   end

   always_comb begin
      state_next         = state_reg;
      state_next.started = 1'b1;
      state_next.rdata   = '0;
      if (wr) begin
         unique case (paddr)
            SSPF_CFG_OFS: begin
               state_next.count  = (pwdata[1:0] == 2'h3) ? SSPF_CNT_ONE
                                   : sspf_count_e'(pwdata[1:0]);
               state_next.func_one = (pwdata[4:2] > 3'h4) ? SSPF_FN_NONE
                                     : sspf_func_e'(pwdata[4:2]);
               state_next.func_two = (pwdata[7:5] > 3'h4) ? SSPF_FN_NONE
                                     : sspf_func_e'(pwdata[7:5]);
               state_next.ch_one = {1'b0, pwdata[8]};
               state_next.ch_two = {1'b0, pwdata[9]};
               state_next.dir    = (pwdata[11:10] == 2'h3) ? SSPF_DIR_HEAT
                                   : sspf_dir_e'(pwdata[11:10]);
               state_next.onoff  = pwdata[12];
               // Dropping the count disables affected inputs
               if (state_reg.count == SSPF_CNT_FOUR && pwdata[1:0] == 2'h1) begin
                  state_next.func_two = SSPF_FN_NONE;
               end else if (state_reg.count == SSPF_CNT_FOUR && pwdata[1:0] != 2'h2) begin
                  state_next.func_one = SSPF_FN_NONE;
                  state_next.func_two = SSPF_FN_NONE;
               end
            end
            SSPF_LIM_OFS: begin
               state_next.sp_lo = pwdata[15:0];
               state_next.sp_hi = pwdata[31:16];
            end
            SSPF_LEVEL_OFS: begin
               state_next.halt_lvl  = clamp_lvl(pwdata[11:0], state_reg.dir, state_reg.onoff);
               state_next.fault_lvl = clamp_lvl(pwdata[23:12], state_reg.dir,
                                                state_reg.onoff);
            end
            SSPF_CMD_OFS: begin
               if (!(bank_one | bank_two)) begin
                  state_next.bus_index = pwdata[1:0];
               end
               state_next.bus_halt   = pwdata[3:2];
               state_next.bus_alclr  = pwdata[5:4];
               state_next.bus_manual = pwdata[7:6];
               state_next.manual_lvl = clamp_lvl(pwdata[19:8], state_reg.dir, 1'b0);
               if (pwdata[31]) begin
                  // Factory restore; bus interface state is untouched
                  state_next.count      = SSPF_CNT_ONE;
                  state_next.func_one   = SSPF_FN_NONE;
                  state_next.func_two   = SSPF_FN_NONE;
                  state_next.ch_one     = SSPF_CH_ONE;
                  state_next.ch_two     = SSPF_CH_TWO;
                  state_next.dir        = SSPF_DIR_HEAT;
                  state_next.onoff      = 1'b0;
                  state_next.bus_index  = 2'h0;
                  state_next.bus_halt   = 2'h0;
                  state_next.bus_alclr  = 2'h0;
                  state_next.bus_manual = 2'h0;
                  state_next.sp         = '0;
                  state_next.sp_lo      = '0;
                  state_next.sp_hi      = 16'hFFFF;
                  state_next.halt_lvl   = '0;
                  state_next.fault_lvl  = '0;
                  state_next.manual_lvl = '0;
               end
            end
            default: begin
               if (paddr >= SSPF_SP_BASE_OFS && paddr < SSPF_LIM_OFS) begin
                  state_next.sp[16*sp_ofs[3:2] +: 16] =
                     (pwdata[15:0] < state_reg.sp_lo) ? state_reg.sp_lo :
                     (pwdata[15:0] > state_reg.sp_hi) ? state_reg.sp_hi :
                     pwdata[15:0];
               end
            end
         endcase
      end
      // Bank select needs at least two setpoints
      if (state_next.count == SSPF_CNT_ONE) begin
         if (state_next.func_one == SSPF_FN_BANK) state_next.func_one = SSPF_FN_NONE;
         if (state_next.func_two == SSPF_FN_BANK) state_next.func_two = SSPF_FN_NONE;
      end
      if (rd) begin
         unique case (paddr)
            SSPF_CFG_OFS:    state_next.rdata = {19'h0, state_reg.onoff, state_reg.dir,
                                                 state_reg.ch_two[0], state_reg.ch_one[0],
                                                 state_reg.func_two, state_reg.func_one,
                                                 state_reg.count};
            SSPF_LIM_OFS:    state_next.rdata = {state_reg.sp_hi, state_reg.sp_lo};
            SSPF_LEVEL_OFS:  state_next.rdata = {8'h0, state_reg.fault_lvl, state_reg.halt_lvl};
            SSPF_CMD_OFS:    state_next.rdata = {12'h0, state_reg.manual_lvl,
                                                 state_reg.bus_manual, state_reg.bus_alclr,
                                                 state_reg.bus_halt, state_reg.bus_index};
            SSPF_INPUT_OFS:  state_next.rdata = {24'h0, man_v, alclr_v, halt_v, act};
            SSPF_STATUS_OFS: state_next.rdata = {24'h0, setpoint_index, fault_ch2, fault_ch1};
            SSPF_OUT_OFS:    state_next.rdata = {8'h0, state_reg.mv};
            default: begin
               if (paddr >= SSPF_SP_BASE_OFS && paddr < SSPF_LIM_OFS) begin
                  state_next.rdata = {16'h0, state_reg.sp[16*sp_ofs[3:2] +: 16]};
               end
            end
         endcase
      end
      // Half-second blink while any fault stands
      if (!fault_any) begin
         state_next.blink_cnt = '0;
         state_next.blink     = 1'b0;
      end else if (state_reg.blink_cnt >= BLINK_CYC - 1) begin
         state_next.blink_cnt = '0;
         state_next.blink     = ~state_reg.blink;
      end else begin
         state_next.blink_cnt = state_reg.blink_cnt + 32'h1;
      end
      // Priority mux
      if (man_v[0]) begin
         state_next.mv = manual_out;
      end else if (halt_v[0]) begin
         state_next.mv = halt_out;
      end else if (fault_any) begin
         state_next.mv = fault_out;
      end else begin
         state_next.mv = control_output_level;
      end
   end

   always_comb begin
      setpoint_index = state_reg.bus_index;
      if (bank_one && bank_two) begin
         setpoint_index = act;
      end else if (bank_one) begin
         setpoint_index = {1'b0, act[0]};
      end else if (bank_two) begin
         setpoint_index = {1'b0, act[1]};
      end
      if (state_reg.count == SSPF_CNT_ONE) begin
         setpoint_index = 2'h0;
      end else if (state_reg.count == SSPF_CNT_TWO) begin
         setpoint_index[1] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg            <= '0;
         state_reg.ch_two     <= SSPF_CH_TWO;
         state_reg.sp_hi      <= 16'hFFFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign setpoint           = state_reg.sp[16*setpoint_index +: 16];
   assign prdata             = state_reg.rdata;
   assign pready             = psel & penable;
   assign pslverr            = 1'b0;
   assign manipulated_value  = state_reg.mv;
   assign halt_ch            = halt_v;
   assign alarm_force_off_ch = alclr_v;
   assign manual_ch          = man_v;
   assign fault_flag         = fault_any;
   assign indicator          = state_reg.blink;
endmodule

// File: bench/sspf_field_model.sv
/*
 Model of the two external contacts that sit in front of sspf_top.
 Assumes the bench asks for a contact state; slow mode makes the
 contacts settle three cycles late, as a sluggish relay would.
*/
module sspf_field_model (
   // Clock
   input  wire logic       pclk,
   // Requests from the bench
   input  wire logic       slow,
   input  wire logic [1:0] close_req,
   // Contacts, bit0 is input one
   output logic      [1:0] contacts
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned wait_q;

   initial begin
      contacts = 2'b00;
      wait_q = 0;
   end

   // Contacts move just after a rising edge, like any other design input
   always @(posedge pclk) begin
      if (close_req == contacts) begin
         wait_q <= 0;
      end else if (!slow || wait_q == 3) begin
         contacts <= close_req;
         wait_q <= 0;
      end else begin
         wait_q <= wait_q + 1;
      end
   end
endmodule

// File: bench/sspf_properties.sv
/*
 Port checker for sspf_top.
 Bound to every sspf_top instance; sees its ports only.
*/
module sspf_properties
   import sspf_pkg::*;
#(
   parameter int unsigned BLINK_CYC = 8
) (
   // Clock, reset, bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   // Field side
   input wire logic        contact_input_one,
   input wire logic        contact_input_two,
   input wire sspf_fault_s fault_ch1,
   input wire sspf_fault_s fault_ch2,
   // Results
   input wire sspf_level_s manipulated_value,
   input wire logic [1:0]  setpoint_index,
   input wire logic [1:0]  halt_ch,
   input wire logic [1:0]  alarm_force_off_ch,
   input wire logic [1:0]  manual_ch,
   input wire logic        fault_flag,
   input wire logic        indicator
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   assign wr = psel && penable && pwrite;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_zero_wait_a: assert property (pready == (psel && penable))
      else $error("pready not tied to access phase");
   no_slave_err_a: assert property (!pslverr)
      else $error("pslverr raised");
   fault_flag_or_a: assert property (fault_flag == ((|fault_ch1) || (|fault_ch2)))
      else $error("fault flag does not follow faults");
   blink_cause_a: assert property ($rose(indicator) |-> $past(fault_flag))
      else $error("indicator rose without fault");
   // Two edges of delay at least, one from each flop stage
   contact_sync_a: assert property (($changed(contact_input_one)
      || $changed(contact_input_two)) && !wr
      |=> $stable({halt_ch, alarm_force_off_ch, manual_ch, setpoint_index}))
      else $error("contact acted without synchroniser delay");
   halt_hold_a: assert property ((halt_ch[0] && !manual_ch[0] && !wr)[*3]
      |-> $stable(manipulated_value)) else $error("halt level not held");
   manual_hold_a: assert property ((manual_ch[0] && !wr)[*3]
      |-> $stable(manipulated_value)) else $error("manual level not held");
   reset_quiet_a: assert property (!$past(presetn)
      |-> (halt_ch == 2'h0) && (manual_ch == 2'h0) && (alarm_force_off_ch == 2'h0))
      else $error("contact function active right after reset");

   cover property (halt_ch[0] && fault_flag);
   cover property (manual_ch[0] && halt_ch[0]);
   cover property ($rose(indicator));
   cover property (setpoint_index == 2'h3);
endmodule

bind sspf_top sspf_properties #(.BLINK_CYC(BLINK_CYC)) sspf_properties_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
   .contact_input_one, .contact_input_two, .fault_ch1, .fault_ch2,
   .manipulated_value, .setpoint_index, .halt_ch, .alarm_force_off_ch,
   .manual_ch, .fault_flag, .indicator
);

// File: bench/sspf_tb_top.sv
/*
 Self-checking bench for sspf_top: APB master tasks and directed tests.
 Assumes zero-wait APB and the contact model in sspf_field_model.
*/
module sspf_tb_top
   import sspf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, slow, fault_flag, indicator;
   logic        pready, pslverr, ind_prev;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  close_req, contacts, sp_idx, halt_ch, alclr_ch, man_ch, ex;
   logic [15:0] sp_val;
   logic [15:0] sp_exp [4];
   logic [31:0] sp_wr [4];
   sspf_fault_s fault_ch1, fault_ch2;
   sspf_level_s ctl_lvl, mv;
   int          err_count, n_checks, toggles;

   // Short blink count keeps the run brief
   sspf_top #(.BLINK_CYC(8)) sspf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .contact_input_one(contacts[0]),
      .contact_input_two(contacts[1]), .fault_ch1(fault_ch1), .fault_ch2(fault_ch2),
      .control_output_level(ctl_lvl), .manipulated_value(mv), .setpoint_index(sp_idx),
      .setpoint(sp_val), .halt_ch(halt_ch), .alarm_force_off_ch(alclr_ch),
      .manual_ch(man_ch), .fault_flag(fault_flag), .indicator(indicator));
   sspf_field_model sspf_field_model_inst (.pclk(pclk), .slow(slow),
      .close_req(close_req), .contacts(contacts));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expd);
      n_checks++;
      if (seen !== expd) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, expd, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk("pslverr", {31'h0, pslverr}, 32'h0);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] addr, input logic [31:0] expd, input string what);
      apb(1'b0, addr, 32'h0);
      chk(what, rd, expd);
   endtask

   // Long enough for the slow contacts plus the synchroniser
   task automatic drive(input logic [1:0] v);
      close_req <= v;
      repeat (10) @(posedge pclk);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      summarize();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, close_req, slow} = '0;
      fault_ch1 = '0;
      fault_ch2 = '0;
      ctl_lvl = {12'sh1F4, 12'sh190};
      err_count = 0;
      n_checks = 0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rchk(SSPF_CFG_OFS, 32'h200, "cfg");
      rchk(SSPF_LIM_OFS, 32'hFFFF0000, "limits");
      rchk(SSPF_SP_BASE_OFS, 32'h0, "sp0");
      rchk(8'h3C, 32'h0, "unmapped");
      apb(1'b1, SSPF_LIM_OFS, 32'h03E8000A);
      sp_wr = '{32'h5, 32'h64, 32'h7D0, 32'h1F4};
      sp_exp = '{16'h000A, 16'h0064, 16'h03E8, 16'h01F4};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, SSPF_SP_BASE_OFS + 8'(4 * i), sp_wr[i]);
         rchk(SSPF_SP_BASE_OFS + 8'(4 * i), {16'h0, sp_exp[i]}, "sp clamp");
      end
      apb(1'b1, SSPF_CFG_OFS, 32'h211);
      for (int i = 0; i < 2; i++) begin
         drive({1'b0, i[0]});
         chk("index one bank", {30'h0, sp_idx}, i);
         chk("setpoint", {16'h0, sp_val}, {16'h0, sp_exp[i]});
      end
      slow <= 1'b1;
      apb(1'b1, SSPF_CFG_OFS, 32'h292);
      for (int i = 0; i < 4; i++) begin
         drive(i[1:0]);
         chk("index two banks", {30'h0, sp_idx}, i);
         chk("setpoint", {16'h0, sp_val}, {16'h0, sp_exp[i]});
      end
      drive(2'b00);
      apb(1'b1, SSPF_CMD_OFS, 32'h1);
      chk("bus index ignored", {30'h0, sp_idx}, 32'h0);
      rchk(SSPF_CMD_OFS, 32'h0, "bus index kept");
      slow <= 1'b0;
      apb(1'b1, SSPF_CFG_OFS, 32'h291);
      rchk(SSPF_CFG_OFS, 32'h211, "drop to two");
      apb(1'b1, SSPF_CFG_OFS, 32'h292);
      apb(1'b1, SSPF_CFG_OFS, 32'h290);
      rchk(SSPF_CFG_OFS, 32'h200, "drop to one");
      apb(1'b1, SSPF_CFG_OFS, 32'h210);
      drive(2'b01);
      chk("bank with one", {30'h0, sp_idx}, 32'h0);
      drive(2'b00);
      for (int f = 1; f < 4; f++) begin
         for (int c = 0; c < 2; c++) begin
            apb(1'b1, SSPF_CFG_OFS, 32'h200 | (f << 2) | (c << 8));
            drive(2'b01);
            ex = c ? 2'b10 : 2'b01;
            chk("halt", {30'h0, halt_ch}, f == 1 ? ex : 2'b00);
            chk("alarm off", {30'h0, alclr_ch}, f == 2 ? ex : 2'b00);
            chk("manual", {30'h0, man_ch}, f == 3 ? ex : 2'b00);
            drive(2'b00);
            chk("released", {26'h0, halt_ch, alclr_ch, man_ch}, 32'h0);
         end
      end
      for (int d = 0; d < 3; d++) begin
         for (int u = 0; u < 2; u++) begin
            apb(1'b1, SSPF_CFG_OFS, 32'h200 | (d << 10));
            fault_ch1 <= u ? 3'b010 : 3'b100;
            repeat (3) @(posedge pclk);
            chk("fault flag", {31'h0, fault_flag}, 32'h1);
            if (d != 1) chk("heat", {20'h0, mv.heat}, u ? 32'h3E8 : 32'h0);
            if (d != 0) chk("cool", {20'h0, mv.cool}, u ? 32'h0 : 32'h3E8);
         end
      end
      fault_ch1 <= '0;
      repeat (3) @(posedge pclk);
      chk("flag clear", {31'h0, fault_flag}, 32'h0);
      chk("resume", {20'h0, mv.heat}, 32'h1F4);
      apb(1'b1, SSPF_CFG_OFS, 32'h200);
      apb(1'b1, SSPF_LEVEL_OFS, 32'h000C812C);
      fault_ch2 <= 3'b001;
      repeat (3) @(posedge pclk);
      chk("ch2 flag", {31'h0, fault_flag}, 32'h1);
      fault_ch1 <= 3'b001;
      repeat (3) @(posedge pclk);
      chk("open level", {20'h0, mv.heat}, 32'h0C8);
      toggles = 0;
      ind_prev = indicator;
      repeat (32) begin
         @(posedge pclk);
         if (indicator !== ind_prev) toggles++;
         ind_prev = indicator;
      end
      chk("blinks", toggles, 32'h4);
      apb(1'b1, SSPF_CFG_OFS, 32'h02C);
      drive(2'b10);
      chk("auto halt wins", {20'h0, mv.heat}, 32'h12C);
      apb(1'b1, SSPF_CMD_OFS, 32'h0002BC00);
      drive(2'b11);
      chk("manual wins", {20'h0, mv.heat}, 32'h2BC);
      drive(2'b01);
      chk("manual over fault", {20'h0, mv.heat}, 32'h2BC);
      drive(2'b00);
      fault_ch1 <= '0;
      fault_ch2 <= '0;
      apb(1'b1, SSPF_CMD_OFS, 32'h80000000);
      rchk(SSPF_CFG_OFS, 32'h200, "restore cfg");
      rchk(SSPF_SP_BASE_OFS + 8'h4, 32'h0, "restore sp1");
      rchk(SSPF_LIM_OFS, 32'hFFFF0000, "restore limits");
      rchk(SSPF_LEVEL_OFS, 32'h0, "restore levels");
      apb(1'b1, SSPF_CFG_OFS, 32'h1200);
      apb(1'b1, SSPF_LEVEL_OFS, 32'h000C812C);
      rchk(SSPF_LEVEL_OFS, 32'h003E83E8, "on/off levels");
      summarize();
   end
endmodule
